// [arl_top.sv]
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module arl_top
    import arl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire arl_conv_t conv_a_i,
    input wire arl_conv_t conv_b_i,
    input wire logic lockstep_parallel_i,
    input wire logic [ARL_ADDR_W-1:0] addr_i,
    input wire logic [ARL_REG_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ARL_REG_W-1:0] rdata_o,
    output logic upper_irq_o,
    output logic lower_irq_o,
    output logic sign_change_irq_o
);

    localparam int FW = ARL_FLD_MSB - ARL_FLD_LSB + 1;
    localparam logic [FW-1:0] HI_FIELD_RESET = ARL_HI_DISABLE[ARL_FLD_MSB:ARL_FLD_LSB];
    localparam logic [FW-1:0] LO_FIELD_RESET = ARL_LO_DISABLE[ARL_FLD_MSB:ARL_FLD_LSB];
    localparam logic [FW-1:0] OFS_FIELD_RESET = ARL_OFS_RESET[ARL_FLD_MSB:ARL_FLD_LSB];

    // =========================================================
    // Bus field positions
    // =========================================================
    // Status words: upper bits fill the high byte, lower bits the low byte
    localparam int LO_BYTE_MSB = ARL_SLOTS - 1;
    localparam int HI_BYTE_LSB = ARL_SLOTS;
    localparam int HI_BYTE_MSB = 2 * ARL_SLOTS - 1;
    localparam int IDX_MSB = ARL_SLOT_W - 1;
    localparam int GRP_LSB = ARL_SLOT_W;
    localparam int ZC_PAD_W = ARL_REG_W - ARL_SLOTS;
    localparam int CTRL_PAD_W = ARL_REG_W - ARL_CTRL_W;

    // =========================================================
    // Storage
    // =========================================================
    logic [ARL_SLOTS-1:0][ARL_REG_W-1:0] result_r;
    logic [ARL_SLOTS-1:0][FW-1:0] lower_r;
    logic [ARL_SLOTS-1:0][FW-1:0] upper_r;
    logic [ARL_SLOTS-1:0][FW-1:0] offset_r;
    logic [ARL_SLOTS-1:0] upper_stat_r;
    logic [ARL_SLOTS-1:0] lower_stat_r;
    logic [ARL_SLOTS-1:0] zc_stat_r;
    logic [ARL_SLOTS-1:0] prev_neg_r;
    logic [2*ARL_SLOTS-1:0] zcc_r;
    logic [ARL_CTRL_W-1:0] ctrl_r;
    logic [ARL_REG_W-1:0] rdata_r;

    // =========================================================
    // Bus decode
    // =========================================================
    logic [2:0] grp;
    logic [2:0] idx;
    logic wr_misc;
    logic [ARL_SLOTS-1:0] wr_result;
    logic [ARL_SLOTS-1:0] wr_lower;
    logic [ARL_SLOTS-1:0] wr_upper;
    logic [ARL_SLOTS-1:0] wr_offset;
    logic [FW-1:0] wfield;

    assign grp = addr_i[ARL_ADDR_W-1:GRP_LSB];
    assign idx = addr_i[IDX_MSB:0];
    assign wr_misc = wr_i && (grp == ARL_GRP_MISC);
    // Reserved bits of the written word are dropped here
    assign wfield = wdata_i[ARL_FLD_MSB:ARL_FLD_LSB];

    // =========================================================
    // Lane B slot: in lockstep mode it pairs with lane A, plus 4
    // =========================================================
    logic [ARL_SLOT_W-1:0] slot_b;

    // Lane A runs slots 0..3, lane B mirrors it in 4..7
    assign slot_b = lockstep_parallel_i ? {1'b1, conv_a_i.slot[ARL_SLOT_W-2:0]}
                                        : conv_b_i.slot;

    // =========================================================
    // Per-slot datapath
    // =========================================================
    logic [ARL_SLOTS-1:0] conv_hit;
    logic [ARL_SLOTS-1:0][FW:0] conv_diff;
    logic [ARL_SLOTS-1:0][FW:0] sw_diff;
    logic [ARL_SLOTS-1:0] upper_set;
    logic [ARL_SLOTS-1:0] lower_set;
    logic [ARL_SLOTS-1:0] zc_set;

    genvar n;
    generate
        for (n = 0; n < ARL_SLOTS; n++) begin : g_slot
            logic hit_a;
            logic hit_b;
            logic [FW-1:0] raw;
            logic now_neg;
            logic [1:0] sel;

            assign hit_a = conv_a_i.done && (conv_a_i.slot == ARL_SLOT_W'(n));
            assign hit_b = conv_b_i.done && (slot_b == ARL_SLOT_W'(n));
            assign conv_hit[n] = hit_a || hit_b;
            assign raw = hit_a ? conv_a_i.raw : conv_b_i.raw;

            // One bit wider than the field so the borrow becomes the sign
            assign conv_diff[n] = {1'b0, raw} - {1'b0, offset_r[n]};
            assign sw_diff[n] = {1'b0, wfield} - {1'b0, offset_r[n]};

            assign wr_result[n] = wr_i && (grp == ARL_GRP_RESULT) && (idx == 3'(n));
            assign wr_lower[n] = wr_i && (grp == ARL_GRP_LOWER) && (idx == 3'(n));
            assign wr_upper[n] = wr_i && (grp == ARL_GRP_UPPER) && (idx == 3'(n));
            assign wr_offset[n] = wr_i && (grp == ARL_GRP_OFFSET) && (idx == 3'(n));

            // Limits look at the uncorrected code, own pair only
            assign upper_set[n] = conv_hit[n]
                                  && (upper_r[n] != HI_FIELD_RESET)
                                  && (raw > upper_r[n]);
            assign lower_set[n] = conv_hit[n]
                                  && (lower_r[n] != LO_FIELD_RESET)
                                  && (raw < lower_r[n]);

            assign now_neg = conv_diff[n][FW];
            assign sel = zcc_r[2*n+1 -: 2];

            always_comb begin
                case (sel)
                    ARL_ZC_POS_TO_NEG: zc_set[n] = conv_hit[n] && !prev_neg_r[n] && now_neg;
                    ARL_ZC_NEG_TO_POS: zc_set[n] = conv_hit[n] && prev_neg_r[n] && !now_neg;
                    ARL_ZC_ANY: zc_set[n] = conv_hit[n] && (prev_neg_r[n] != now_neg);
                    default: zc_set[n] = 1'b0;
                endcase
            end
        end
    endgenerate

    // =========================================================
    // Result registers
    // =========================================================
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_r <= '{default: ARL_RES_RESET};
        end else begin
            for (int i = 0; i < ARL_SLOTS; i++) begin
                // A finishing conversion outranks a software write
                if (conv_hit[i]) begin
                    result_r[i] <= {conv_diff[i], ARL_LOW_PAD};
                end else if (wr_result[i]) begin
                    result_r[i] <= {sw_diff[i], ARL_LOW_PAD};
                end
            end
        end
    end

    // =========================================================
    // Previous sign memory
    // =========================================================
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_neg_r <= '0;
        end else begin
            for (int i = 0; i < ARL_SLOTS; i++) begin
                // Only conversions move it, so a software result write never fakes a crossing
                if (conv_hit[i]) begin
                    prev_neg_r[i] <= conv_diff[i][FW];
                end
            end
        end
    end

    // =========================================================
    // Limit and offset registers
    // =========================================================
    // The all-ones field doubles as the disable code, so no sample can exceed it
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            upper_r <= '{default: HI_FIELD_RESET};
        end else begin
            for (int i = 0; i < ARL_SLOTS; i++) begin
                if (wr_upper[i]) begin
                    upper_r[i] <= wfield;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lower_r <= '{default: LO_FIELD_RESET};
        end else begin
            for (int i = 0; i < ARL_SLOTS; i++) begin
                if (wr_lower[i]) begin
                    lower_r[i] <= wfield;
                end
            end
        end
    end

    // A new offset only affects later conversions and result writes; stored results keep theirs
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            offset_r <= '{default: OFS_FIELD_RESET};
        end else begin
            for (int i = 0; i < ARL_SLOTS; i++) begin
                if (wr_offset[i]) begin
                    offset_r[i] <= wfield;
                end
            end
        end
    end

    // =========================================================
    // Control and edge select
    // =========================================================
    logic wr_ctrl;
    logic wr_zcc;

    assign wr_ctrl = wr_misc && (idx == ARL_MISC_CTRL);
    assign wr_zcc = wr_misc && (idx == ARL_MISC_ZCC);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= '0;
        end else if (wr_ctrl) begin
            // Enables gate the requests only; status keeps collecting while off
            ctrl_r <= wdata_i[ARL_CTRL_W-1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zcc_r <= '0;
        end else if (wr_zcc) begin
            zcc_r <= wdata_i;
        end
    end

    // =========================================================
    // Sticky status, write one to clear, set wins
    // =========================================================
    logic [ARL_SLOTS-1:0] upper_clr;
    logic [ARL_SLOTS-1:0] lower_clr;
    logic [ARL_SLOTS-1:0] zc_clr;

    logic clr_lstat;
    logic clr_zcstat;

    assign clr_lstat = wr_misc && (idx == ARL_MISC_LSTAT);
    assign clr_zcstat = wr_misc && (idx == ARL_MISC_ZCSTAT);
    assign upper_clr = clr_lstat ? wdata_i[HI_BYTE_MSB:HI_BYTE_LSB] : '0;
    assign lower_clr = clr_lstat ? wdata_i[LO_BYTE_MSB:0] : '0;
    // The reserved high byte of the sign status word clears nothing
    assign zc_clr = clr_zcstat ? wdata_i[LO_BYTE_MSB:0] : '0;

    // Set is ORed in after the clear so a same-cycle event is never lost
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            upper_stat_r <= '0;
        end else begin
            upper_stat_r <= (upper_stat_r & ~upper_clr) | upper_set;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lower_stat_r <= '0;
        end else begin
            lower_stat_r <= (lower_stat_r & ~lower_clr) | lower_set;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zc_stat_r <= '0;
        end else begin
            zc_stat_r <= (zc_stat_r & ~zc_clr) | zc_set;
        end
    end

    // =========================================================
    // Summary flags and interrupt requests
    // =========================================================
    logic upper_summary_flag;
    logic lower_summary_flag;
    logic sign_change_summary_flag;

    // Flags drop only once every contributing bit has been cleared
    assign upper_summary_flag = |upper_stat_r;
    assign lower_summary_flag = |lower_stat_r;
    assign sign_change_summary_flag = |zc_stat_r;

    // Levels, not pulses: a request stays up until software clears every status bit or its enable bit
    assign upper_irq_o = upper_summary_flag && ctrl_r[ARL_UPPER_BIT];
    assign lower_irq_o = lower_summary_flag && ctrl_r[ARL_LOWER_BIT];
    assign sign_change_irq_o = sign_change_summary_flag && ctrl_r[ARL_ZC_BIT];

    // =========================================================
    // Read path: data valid only in the cycle after the strobe
    // =========================================================
    logic [ARL_REG_W-1:0] rdata_nxt;
    logic [ARL_REG_W-1:0] lstat_word;
    logic [ARL_REG_W-1:0] zcstat_word;
    logic [ARL_REG_W-1:0] ctrl_word;
    logic [ARL_REG_W-1:0] summary_word;
    logic [ARL_REG_W-1:0] lower_word;
    logic [ARL_REG_W-1:0] upper_word;
    logic [ARL_REG_W-1:0] offset_word;

    assign lstat_word = {upper_stat_r, lower_stat_r};
    assign zcstat_word = {{ZC_PAD_W{1'b0}}, zc_stat_r};
    assign ctrl_word = {{CTRL_PAD_W{1'b0}}, ctrl_r};
    assign summary_word = {{CTRL_PAD_W{1'b0}}, sign_change_summary_flag,
                           lower_summary_flag, upper_summary_flag};
    // Bit 15 and the pad are not stored, so they always read back as zero
    assign lower_word = {1'b0, lower_r[idx], ARL_LOW_PAD};
    assign upper_word = {1'b0, upper_r[idx], ARL_LOW_PAD};
    assign offset_word = {1'b0, offset_r[idx], ARL_LOW_PAD};

    always_comb begin
        rdata_nxt = '0;
        case (grp)
            ARL_GRP_MISC: begin
                case (idx)
                    ARL_MISC_LSTAT: rdata_nxt = lstat_word;
                    ARL_MISC_ZCSTAT: rdata_nxt = zcstat_word;
                    ARL_MISC_CTRL: rdata_nxt = ctrl_word;
                    ARL_MISC_ZCC: rdata_nxt = zcc_r;
                    ARL_MISC_SUMMARY: rdata_nxt = summary_word;
                    default: rdata_nxt = '0;
                endcase
            end
            ARL_GRP_RESULT: rdata_nxt = result_r[idx];
            ARL_GRP_LOWER: rdata_nxt = lower_word;
            ARL_GRP_UPPER: rdata_nxt = upper_word;
            ARL_GRP_OFFSET: rdata_nxt = offset_word;
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= '0;
        end else if (rd_i) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata_o = rdata_r;

endmodule

// [arl_pkg.sv]
// =============================================================
// Result, limit and zero crossing stage: shared definitions
// =============================================================
package arl_pkg;

    // =========================================================
    // Geometry
    // =========================================================
    localparam int ARL_SLOTS = 8;
    localparam int ARL_SLOT_W = 3;
    localparam int ARL_RAW_W = 12;
    localparam int ARL_REG_W = 16;
    localparam int ARL_ADDR_W = 6;

    // =========================================================
    // Field layout shared by result, offset and limit registers
    // =========================================================
    localparam int ARL_FLD_LSB = 3;
    localparam int ARL_FLD_MSB = 14;
    localparam int ARL_SIGN_BIT = 15;
    localparam logic [2:0] ARL_LOW_PAD = 3'h0;

    // =========================================================
    // Reset and disable values of the limits, reset values of offset and result
    // =========================================================
    localparam logic [15:0] ARL_HI_DISABLE = 16'h7ff8;
    localparam logic [15:0] ARL_LO_DISABLE = 16'h0000;
    localparam logic [15:0] ARL_OFS_RESET = 16'h0000;
    localparam logic [15:0] ARL_RES_RESET = 16'h0000;

    // =========================================================
    // Register map: addr[5:3] selects a group, addr[2:0] a slot, or a register in the misc group
    // =========================================================
    localparam logic [2:0] ARL_GRP_MISC = 3'h0;
    localparam logic [2:0] ARL_GRP_RESULT = 3'h1;
    localparam logic [2:0] ARL_GRP_LOWER = 3'h2;
    localparam logic [2:0] ARL_GRP_UPPER = 3'h3;
    localparam logic [2:0] ARL_GRP_OFFSET = 3'h4;

    localparam logic [2:0] ARL_MISC_LSTAT = 3'h0;
    localparam logic [2:0] ARL_MISC_ZCSTAT = 3'h1;
    localparam logic [2:0] ARL_MISC_CTRL = 3'h2;
    localparam logic [2:0] ARL_MISC_ZCC = 3'h3;
    localparam logic [2:0] ARL_MISC_SUMMARY = 3'h4;

    // Interrupt enable bits, also the summary flag positions
    localparam int ARL_UPPER_BIT = 0;
    localparam int ARL_LOWER_BIT = 1;
    localparam int ARL_ZC_BIT = 2;
    localparam int ARL_CTRL_W = 3;

    // =========================================================
    // Edge select encodings, two bits per slot
    // =========================================================
    localparam logic [1:0] ARL_ZC_OFF = 2'h0;
    localparam logic [1:0] ARL_ZC_POS_TO_NEG = 2'h1;
    localparam logic [1:0] ARL_ZC_NEG_TO_POS = 2'h2;
    localparam logic [1:0] ARL_ZC_ANY = 2'h3;

    // One converter lane: end-of-conversion strobe, slot, raw code
    typedef struct packed {
        logic done;
        logic [ARL_SLOT_W-1:0] slot;
        logic [ARL_RAW_W-1:0] raw;
    } arl_conv_t;

endpackage

// [arl_properties.sv]
`timescale 1ns/1ps
// ============================================================
// Checker on the register port and request lines
// ============================================================
module arl_checker
    import arl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire arl_conv_t conv_a_i,
    input wire arl_conv_t conv_b_i,
    input wire logic lockstep_parallel_i,
    input wire logic [ARL_ADDR_W-1:0] addr_i,
    input wire logic [ARL_REG_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ARL_REG_W-1:0] rdata_o,
    input wire logic upper_irq_o,
    input wire logic lower_irq_o,
    input wire logic sign_change_irq_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence rd_grp(logic [2:0] g);
        rd_i && addr_i[5:3] == g;
    endsequence
    sequence rd_lstat;
        rd_i && addr_i == 6'h00;
    endsequence
    // A request may only appear after a conversion or any register write
    sequence cause_seen;
        $past(conv_a_i.done || conv_b_i.done || wr_i);
    endsequence

    chk_result_pad_zero: assert property (rd_grp(ARL_GRP_RESULT) |=> rdata_o[2:0] == 3'h0)
        else $error("result low bits not zero");
    chk_bound_pad_zero: assert property ((rd_grp(ARL_GRP_LOWER) or rd_grp(ARL_GRP_UPPER)
        or rd_grp(ARL_GRP_OFFSET)) |=> rdata_o[15] == 1'b0 && rdata_o[2:0] == 3'h0)
        else $error("bound reserved bits not zero");
    chk_zc_reserved: assert property (rd_i && addr_i == 6'h01 |=> rdata_o[15:8] == 8'h00)
        else $error("sign status upper byte not zero");
    chk_upper_rise: assert property ($rose(upper_irq_o) |-> cause_seen)
        else $error("upper request without cause");
    chk_lower_rise: assert property ($rose(lower_irq_o) |-> cause_seen)
        else $error("lower request without cause");
    chk_zc_rise: assert property ($rose(sign_change_irq_o) |-> cause_seen)
        else $error("sign change request without cause");
    chk_req_sticky: assert property ($fell(upper_irq_o) || $fell(lower_irq_o)
        || $fell(sign_change_irq_o) |-> $past(wr_i))
        else $error("request dropped without a write");
    chk_upper_tie: assert property (rd_lstat ##0 upper_irq_o |=> rdata_o[15:8] != 8'h00)
        else $error("upper request with no upper status");
    chk_lower_tie: assert property (rd_lstat ##0 lower_irq_o |=> rdata_o[7:0] != 8'h00)
        else $error("lower request with no lower status");
endmodule

bind arl_top arl_checker u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .conv_a_i(conv_a_i),
    .conv_b_i(conv_b_i), .lockstep_parallel_i(lockstep_parallel_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .upper_irq_o(upper_irq_o), .lower_irq_o(lower_irq_o), .sign_change_irq_o(sign_change_irq_o));

// [test_adc_result_limit_zero_cross.sv]
`timescale 1ns/1ps
module test_adc_result_limit_zero_cross;
    import arl_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    arl_conv_t conv_a = '0;
    arl_conv_t conv_b = '0;
    logic lock = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic irq_u;
    logic irq_l;
    logic irq_z;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    arl_top dut_u (.mclk_i(mclk), .rst_n_i(rst_n), .conv_a_i(conv_a), .conv_b_i(conv_b),
        .lockstep_parallel_i(lock), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .upper_irq_o(irq_u), .lower_irq_o(irq_l), .sign_change_irq_o(irq_z));

    always #10 mclk = ~mclk;

    // ============================================================
    // Reporting
    // ============================================================
    task automatic final_report();
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run is under two hundred cycles; the ceiling leaves ample margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    // ============================================================
    // Bus and lane drivers
    // ============================================================
    task automatic wreg(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rreg(input logic [5:0] a, input logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        check(rdata, exp);
    endtask

    task automatic irqs(input logic [2:0] exp);
        @(negedge mclk);
        check({13'h0, irq_z, irq_l, irq_u}, {13'h0, exp});
    endtask

    task automatic conv(input logic [2:0] s, input logic [11:0] r);
        @(posedge mclk);
        conv_a <= '{done: 1'b1, slot: s, raw: r};
        @(posedge mclk);
        conv_a.done <= 1'b0;
    endtask

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_reset();
        for (int n = 0; n < 8; n++) begin
            rreg(6'h18 + 6'(n), ARL_HI_DISABLE);
            rreg(6'h10 + 6'(n), ARL_LO_DISABLE);
            rreg(6'h20 + 6'(n), ARL_OFS_RESET);
            rreg(6'h08 + 6'(n), ARL_RES_RESET);
        end
        rreg(6'h00, 16'h0000);
        wreg(6'h3f, 16'hffff);
        rreg(6'h3f, 16'h0000);
    endtask

    task automatic t_limits();
        wreg(6'h02, 16'h0007);
        rreg(6'h02, 16'h0007);
        wreg(6'h1a, 16'h07f8);
        wreg(6'h13, 16'h0400);
        wreg(6'h22, 16'h0080);
        conv(3'h2, 12'h0ff);
        irqs(3'h0);
        conv(3'h2, 12'h100);
        irqs(3'h1);
        rreg(6'h00, 16'h0400);
        rreg(6'h0a, 16'h0780);
        conv(3'h3, 12'h07f);
        rreg(6'h00, 16'h0408);
        rreg(6'h04, 16'h0003);
        conv(3'h3, 12'h0ff);
        wreg(6'h00, 16'h0000);
        rreg(6'h00, 16'h0408);
        wreg(6'h00, 16'h0400);
        rreg(6'h00, 16'h0008);
        irqs(3'h2);
        // Clear and a fresh event on bit 3 in the same cycle
        @(posedge mclk);
        conv_a <= '{done: 1'b1, slot: 3'h3, raw: 12'h07f};
        addr <= 6'h00;
        wdata <= 16'h0008;
        wr <= 1'b1;
        @(posedge mclk);
        conv_a.done <= 1'b0;
        wr <= 1'b0;
        rreg(6'h00, 16'h0008);
        wreg(6'h00, 16'h0008);
        conv(3'h2, 12'h07f);
        rreg(6'h00, 16'h0000);
        irqs(3'h0);
    endtask

    task automatic t_disabled();
        conv(3'h5, 12'hfff);
        conv(3'h6, 12'h000);
        rreg(6'h00, 16'h0000);
        rreg(6'h0d, 16'h7ff8);
    endtask

    task automatic t_negative();
        wreg(6'h21, 16'h1000);
        conv(3'h1, 12'h100);
        rreg(6'h09, 16'hf800);
        wreg(6'h09, 16'hffff);
        rreg(6'h09, 16'h6ff8);
        wreg(6'h09, 16'h0007);
        rreg(6'h09, 16'hf000);
        wreg(6'h11, 16'hffff);
        rreg(6'h11, 16'h7ff8);
    endtask

    task automatic t_zero_cross();
        wreg(6'h03, 16'h6003);
        rreg(6'h03, 16'h6003);
        wreg(6'h20, 16'h0800);
        wreg(6'h25, 16'h0800);
        wreg(6'h26, 16'h0800);
        wreg(6'h27, 16'h0800);
        conv(3'h0, 12'h050);
        conv(3'h5, 12'h050);
        conv(3'h7, 12'h050);
        conv(3'h6, 12'h050);
        rreg(6'h01, 16'h0081);
        irqs(3'h4);
        conv(3'h6, 12'h200);
        rreg(6'h01, 16'h00c1);
        rreg(6'h04, 16'h0004);
        // Enable off: status stays, request must drop
        wreg(6'h02, 16'h0003);
        irqs(3'h0);
        rreg(6'h01, 16'h00c1);
        wreg(6'h01, 16'hffff);
        rreg(6'h01, 16'h0000);
        irqs(3'h0);
        rreg(6'h04, 16'h0000);
    endtask

    task automatic t_lockstep();
        @(posedge mclk);
        lock <= 1'b1;
        conv_a <= '{done: 1'b1, slot: 3'h0, raw: 12'h123};
        conv_b <= '{done: 1'b1, slot: 3'h3, raw: 12'h456};
        @(posedge mclk);
        conv_a.done <= 1'b0;
        conv_b.done <= 1'b0;
        lock <= 1'b0;
        rreg(6'h08, 16'h0118);
        rreg(6'h0c, 16'h22b0);
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_limits();
        t_disabled();
        t_negative();
        t_zero_cross();
        t_lockstep();
        final_report();
    end
endmodule
